// ==== pkg/sifc_pkg.sv ====
// Constants and types shared by the serial interrupt frame controller
package sifc_pkg;
  localparam int unsigned SLOTS = 16;
  localparam int unsigned IDX_W = 4;

  // Configuration space byte offsets
  localparam logic [7:0] OFS_MODE_CTRL = 8'hE0;
  localparam logic [7:0] OFS_TRIG_SEL = 8'hE2;
  localparam logic [7:0] OFS_LEVEL_STAT = 8'hE4;

  // Mode control field positions
  localparam int unsigned MODE_DRIVE_BIT = 0;
  localparam int unsigned MODE_POLL_BIT = 1;
  localparam int unsigned MODE_WIDTH_LSB = 2;
  localparam int unsigned MODE_USED_W = 4;

  // Reset values
  localparam logic [3:0] MODE_RST = 4'h0;
  localparam logic [15:0] TRIG_RST = 16'h0000;
  localparam logic [15:0] STAT_RST = 16'h0000;

  // Start width codes and lengths in clocks
  localparam logic [1:0] WIDTH_CODE_6 = 2'h1;
  localparam logic [1:0] WIDTH_CODE_8 = 2'h2;
  localparam logic [3:0] START_CLKS_4 = 4'h4;
  localparam logic [3:0] START_CLKS_6 = 4'h6;
  localparam logic [3:0] START_CLKS_8 = 4'h8;

  // Stop frame lengths and clocks per slot
  localparam logic [3:0] STOP_CLKS_QUIET = 4'h2;
  localparam logic [3:0] STOP_CLKS_CONT = 4'h3;
  localparam logic [3:0] SLOT_PHASES = 4'h3;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_RECOV,
    ST_TURN,
    ST_SLOT,
    ST_STOP,
    ST_PRECOV,
    ST_PTURN
  } sifc_state_t;
endpackage

// ==== pkg/sifc_cfg_if.sv ====
// Carrier between the frame sequencer and its register file
`timescale 1ns/1ps
`default_nettype none
interface sifc_cfg_if;
  logic [1:0] start_width;
  logic polling_style;
  logic recovery_drive_select;
  logic [15:0] trigger_type;
  logic [15:0] level_seen;
  logic smp_valid;
  logic [3:0] smp_idx;
  logic smp_low;
  logic cfg_clear;

  modport regs (
    output start_width, polling_style, recovery_drive_select,
    output trigger_type, level_seen,
    input smp_valid, smp_idx, smp_low, cfg_clear
  );
  modport seq (
    input start_width, polling_style, recovery_drive_select,
    input trigger_type, level_seen,
    output smp_valid, smp_idx, smp_low, cfg_clear
  );
endinterface
`default_nettype wire

// ==== hw/sifc_regs.sv ====
// Configuration registers and level status of the serial interrupt block
`timescale 1ns/1ps
`default_nettype none
module sifc_regs (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  sifc_cfg_if.regs cfg
);
  localparam int TB = int'(sifc_pkg::OFS_TRIG_SEL[1:0]);

  logic [3:0] mode_ff, nxt_mode;
  logic [15:0] trig_ff, nxt_trig;
  logic [15:0] stat_ff, nxt_stat;
  logic [31:0] rdata_ff, nxt_rdata;
  logic ack_ff, nxt_ack;
  logic hit_ctl, hit_stat;
  logic [15:0] clr_mask, set_mask;

  assign hit_ctl = cfg_addr_i[7:2] == sifc_pkg::OFS_MODE_CTRL[7:2];
  assign hit_stat = cfg_addr_i[7:2] == sifc_pkg::OFS_LEVEL_STAT[7:2];

  always_comb
  begin
    nxt_mode = mode_ff;
    nxt_trig = trig_ff;
    clr_mask = 16'h0000;
    set_mask = 16'h0000;
    if (cfg_wr_i && hit_ctl && cfg_be_i[0])
      nxt_mode = cfg_wdata_i[3:0];
    if (cfg_wr_i && hit_ctl && cfg_be_i[TB])
      nxt_trig[7:0] = cfg_wdata_i[8*TB +: 8];
    if (cfg_wr_i && hit_ctl && cfg_be_i[TB+1])
      nxt_trig[15:8] = cfg_wdata_i[8*(TB+1) +: 8];
    if (cfg_wr_i && hit_stat && cfg_be_i[0])
      clr_mask[7:0] = cfg_wdata_i[7:0];
    if (cfg_wr_i && hit_stat && cfg_be_i[1])
      clr_mask[15:8] = cfg_wdata_i[15:8];
    // Only level slots latch; a fresh report wins over a write-one clear
    if (cfg.smp_valid && cfg.smp_low && trig_ff[cfg.smp_idx])
      set_mask[cfg.smp_idx] = 1'b1;
    nxt_stat = (stat_ff & ~clr_mask) | set_mask;
    if (cfg.cfg_clear)
    begin
      nxt_mode = sifc_pkg::MODE_RST;
      nxt_trig = sifc_pkg::TRIG_RST;
      nxt_stat = sifc_pkg::STAT_RST;
    end
    nxt_ack = cfg_rd_i || cfg_wr_i;
    nxt_rdata = 32'h0000_0000;
    if (cfg_rd_i && hit_ctl)
      nxt_rdata = {trig_ff, 8'h00, 4'h0, mode_ff};
    else if (cfg_rd_i && hit_stat)
      nxt_rdata = {16'h0000, stat_ff};
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      mode_ff <= sifc_pkg::MODE_RST;
      trig_ff <= sifc_pkg::TRIG_RST;
      stat_ff <= sifc_pkg::STAT_RST;
      rdata_ff <= 32'h0000_0000;
      ack_ff <= 1'b0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      trig_ff <= nxt_trig;
      stat_ff <= nxt_stat;
      rdata_ff <= nxt_rdata;
      ack_ff <= nxt_ack;
    end
  end

  assign cfg_rdata_o = rdata_ff;
  assign cfg_ack_o = ack_ff;
  assign cfg.start_width = mode_ff[sifc_pkg::MODE_WIDTH_LSB +: 2];
  assign cfg.polling_style = mode_ff[sifc_pkg::MODE_POLL_BIT];
  assign cfg.recovery_drive_select = mode_ff[sifc_pkg::MODE_DRIVE_BIT];
  assign cfg.trigger_type = trig_ff;
  assign cfg.level_seen = stat_ff;

  chk_level_set: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg.smp_valid && cfg.smp_low && trig_ff[cfg.smp_idx]
     && !cfg.cfg_clear) |=> stat_ff[$past(cfg.smp_idx)])
    else $error("level slot report not latched");

  chk_edge_noset: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ##1 ((stat_ff & ~$past(stat_ff) & ~$past(trig_ff)) == 16'h0000))
    else $error("edge slot set its status bit");

  chk_rearm_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg_wr_i && hit_stat && cfg_be_i[0] && cfg_wdata_i[0]
     && !(cfg.smp_valid && cfg.smp_idx == 4'h0)) |=> !stat_ff[0])
    else $error("write one did not re-arm slot 0");

  chk_rsvd_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (cfg_rd_i && hit_ctl) |=> (cfg_rdata_o[7:4] == 4'h0) && cfg_ack_o)
    else $error("reserved mode bits read nonzero");

  chk_cfg_clear: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cfg.cfg_clear |=> (mode_ff == sifc_pkg::MODE_RST)
      && (trig_ff == sifc_pkg::TRIG_RST))
    else $error("link or global reset left config set");
endmodule
`default_nettype wire

// ==== hw/sifc_ctrl.sv ====
// Serial interrupt frame controller top: pins, frame sequencer, status
//
// What this block does
// - Start pulse lasts 4, 6 or 8 clocks
// - Polling bit picks continuous or quiet mode
// - Recovery drives high or releases by bit
// - Mode control bits 7:4 read zero
// - Per-slot edge/level select, reset edge
// - Level slot report sets its status bit
// - Writing one re-arms a latched status
// - Edge slots never set status bits
// - Link, global, power-on reset restore config
`timescale 1ns/1ps
`default_nettype none
module sifc_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic link_reset_n_i,
  input wire logic global_reset_n_i,
  input wire logic cfg_rd_i,
  input wire logic cfg_wr_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_ack_o,
  input wire logic serial_interrupt_line_i,
  output logic serial_interrupt_line_o,
  output logic serial_interrupt_line_oe_o,
  output logic [15:0] irq_req_o
);
  sifc_cfg_if cfg ();

  sifc_regs u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_rd_i(cfg_rd_i),
    .cfg_wr_i(cfg_wr_i),
    .cfg_addr_i(cfg_addr_i),
    .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i),
    .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o),
    .cfg(cfg.regs)
  );

  // Pin synchronisers; first stage feeds only the second
  logic line_s1_ff, line_s2_ff;
  logic link_s1_ff, link_s2_ff;
  logic glob_s1_ff, glob_s2_ff;

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      line_s1_ff <= 1'b1;
      line_s2_ff <= 1'b1;
      link_s1_ff <= 1'b0;
      link_s2_ff <= 1'b0;
      glob_s1_ff <= 1'b0;
      glob_s2_ff <= 1'b0;
    end
    else
    begin
      line_s1_ff <= serial_interrupt_line_i;
      line_s2_ff <= line_s1_ff;
      link_s1_ff <= link_reset_n_i;
      link_s2_ff <= link_s1_ff;
      glob_s1_ff <= global_reset_n_i;
      glob_s2_ff <= glob_s1_ff;
    end
  end

  assign cfg.cfg_clear = !link_s2_ff || !glob_s2_ff;

  function automatic logic [3:0] start_len(input logic [1:0] code);
    case (code)
      sifc_pkg::WIDTH_CODE_6: start_len = sifc_pkg::START_CLKS_6;
      sifc_pkg::WIDTH_CODE_8: start_len = sifc_pkg::START_CLKS_8;
      // Reserved code falls back to the default width
      default: start_len = sifc_pkg::START_CLKS_4;
    endcase
  endfunction

  sifc_pkg::sifc_state_t state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic [3:0] slot_ff, nxt_slot;
  logic [1:0] width_ff, nxt_width;
  logic oe_ff, nxt_oe;
  logic dout_ff, nxt_dout;
  logic smp0_ff, nxt_smp0;
  logic smp1_ff;
  logic [3:0] idx0_ff, idx1_ff;
  logic [15:0] irq_ff, nxt_irq;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_slot = slot_ff;
    nxt_width = width_ff;
    unique case (state_ff)
      sifc_pkg::ST_IDLE:
        // Quiet mode waits for a peripheral to pull the line low
        if (!cfg.polling_style || !line_s2_ff)
        begin
          nxt_state = sifc_pkg::ST_START;
          nxt_width = cfg.start_width;
          nxt_cnt = start_len(cfg.start_width) - 4'h1;
        end
      sifc_pkg::ST_START:
        if (cnt_ff == 4'h0)
          nxt_state = sifc_pkg::ST_RECOV;
        else
          nxt_cnt = cnt_ff - 4'h1;
      sifc_pkg::ST_RECOV:
        nxt_state = sifc_pkg::ST_TURN;
      sifc_pkg::ST_TURN:
      begin
        nxt_state = sifc_pkg::ST_SLOT;
        nxt_slot = 4'h0;
        nxt_cnt = sifc_pkg::SLOT_PHASES - 4'h1;
      end
      sifc_pkg::ST_SLOT:
        if (cnt_ff != 4'h0)
          nxt_cnt = cnt_ff - 4'h1;
        else if (slot_ff == 4'(sifc_pkg::SLOTS - 1))
        begin
          nxt_state = sifc_pkg::ST_STOP;
          nxt_cnt = (cfg.polling_style ? sifc_pkg::STOP_CLKS_QUIET
                     : sifc_pkg::STOP_CLKS_CONT) - 4'h1;
        end
        else
        begin
          nxt_slot = slot_ff + 4'h1;
          nxt_cnt = sifc_pkg::SLOT_PHASES - 4'h1;
        end
      sifc_pkg::ST_STOP:
        if (cnt_ff == 4'h0)
          nxt_state = sifc_pkg::ST_PRECOV;
        else
          nxt_cnt = cnt_ff - 4'h1;
      sifc_pkg::ST_PRECOV:
        nxt_state = sifc_pkg::ST_PTURN;
      sifc_pkg::ST_PTURN:
        nxt_state = sifc_pkg::ST_IDLE;
    endcase
    // Pin drive follows the next state so it lines up with state_ff
    nxt_dout = !(nxt_state == sifc_pkg::ST_START
                 || nxt_state == sifc_pkg::ST_STOP);
    nxt_oe = !nxt_dout
      || ((nxt_state == sifc_pkg::ST_RECOV
           || nxt_state == sifc_pkg::ST_PRECOV)
          && !cfg.recovery_drive_select);
    // Sample phase is the first clock of each slot
    nxt_smp0 = state_ff == sifc_pkg::ST_SLOT
      && cnt_ff == sifc_pkg::SLOT_PHASES - 4'h1;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_ff <= sifc_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      slot_ff <= 4'h0;
      width_ff <= 2'h0;
      oe_ff <= 1'b0;
      dout_ff <= 1'b1;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      slot_ff <= nxt_slot;
      width_ff <= nxt_width;
      oe_ff <= nxt_oe;
      dout_ff <= nxt_dout;
    end
  end

  // Two-stage delay matches the line synchroniser latency
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      smp0_ff <= 1'b0;
      smp1_ff <= 1'b0;
      idx0_ff <= 4'h0;
      idx1_ff <= 4'h0;
    end
    else
    begin
      smp0_ff <= nxt_smp0;
      smp1_ff <= smp0_ff;
      idx0_ff <= slot_ff;
      idx1_ff <= idx0_ff;
    end
  end

  assign cfg.smp_valid = smp1_ff;
  assign cfg.smp_idx = idx1_ff;
  assign cfg.smp_low = !line_s2_ff;

  // Edge slots mirror the last sample; level slots show the latch
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_irq
      assign nxt_irq[gi] = cfg.trigger_type[gi] ? cfg.level_seen[gi]
        : ((smp1_ff && idx1_ff == 4'(gi)) ? !line_s2_ff
           : irq_ff[gi]);
    end
  endgenerate

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      irq_ff <= 16'h0000;
    else
      irq_ff <= nxt_irq;
  end

  assign serial_interrupt_line_o = dout_ff;
  assign serial_interrupt_line_oe_o = oe_ff;
  assign irq_req_o = irq_ff;

  sequence seq_start4;
    (state_ff == sifc_pkg::ST_START)[*4] ##1
    (state_ff == sifc_pkg::ST_RECOV);
  endsequence
  sequence seq_start6;
    (state_ff == sifc_pkg::ST_START)[*6] ##1
    (state_ff == sifc_pkg::ST_RECOV);
  endsequence
  sequence seq_start8;
    (state_ff == sifc_pkg::ST_START)[*8] ##1
    (state_ff == sifc_pkg::ST_RECOV);
  endsequence

  chk_start_four: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($rose(state_ff == sifc_pkg::ST_START) && width_ff == 2'h0)
    |-> seq_start4)
    else $error("start pulse not four clocks");

  chk_start_six: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($rose(state_ff == sifc_pkg::ST_START) && width_ff == 2'h1)
    |-> seq_start6)
    else $error("start pulse not six clocks");

  chk_start_eight: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($rose(state_ff == sifc_pkg::ST_START) && width_ff == 2'h2)
    |-> seq_start8)
    else $error("start pulse not eight clocks");

  chk_recov_drive: assert property (
    @(posedge clk_i) disable iff (rst_i)
    ($rose(state_ff == sifc_pkg::ST_RECOV)
     && !$past(cfg.recovery_drive_select))
    |-> serial_interrupt_line_oe_o && serial_interrupt_line_o)
    else $error("recovery cycle not driven high");

  chk_cont_restart: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == sifc_pkg::ST_IDLE && !cfg.polling_style)
    |=> serial_interrupt_line_oe_o && !serial_interrupt_line_o)
    else $error("continuous mode did not start a frame");

  chk_quiet_wake: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (state_ff == sifc_pkg::ST_IDLE && cfg.polling_style)
    |=> (state_ff == sifc_pkg::ST_START) == !$past(line_s2_ff))
    else $error("quiet mode start not tied to line low");
endmodule
`default_nettype wire

// ==== verif/sifc_periph.sv ====
// Peripheral model driving the shared serial interrupt line
`timescale 1ns/1ps
`default_nettype none
module sifc_periph (
  input wire logic clk_i,
  input wire logic line_i,
  input wire logic [15:0] slot_req_i,
  input wire logic wake_i,
  output logic pull_o
);
  int low_cnt = 0;
  int pos = 0;
  logic wake_ff = 1'b0;
  logic slot_pull;
  // Only a run of 4+ lows is a start; stop runs are shorter
  always @(posedge clk_i)
  begin
    low_cnt <= line_i ? 0 : low_cnt + 1;
    if (line_i && low_cnt >= 4)
      pos <= 6;
    else if (pos != 0 && pos < 60)
      pos <= pos + 1;
    else
      pos <= 0;
    wake_ff <= wake_i;
  end
  // Low in the first clock of its own slot only
  always_comb
  begin
    slot_pull = 1'b0;
    if (pos >= 7 && pos <= 54 && (pos - 7) % 3 == 0)
      slot_pull = slot_req_i[(pos - 7) / 3];
  end
  assign pull_o = wake_ff | slot_pull;
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Self-checking bench for the serial interrupt frame controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic link_n = 1'b1;
  logic glob_n = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [3:0] be = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic ack;
  logic line_o;
  logic line_oe;
  logic pull;
  logic line;
  logic [15:0] irq;
  logic [15:0] slot_req = 16'h0000;
  logic wake = 1'b0;
  int n_errors = 0;
  int checked = 0;

  always #10 clk_i = ~clk_i;
  // Pull-up wins when nobody drives
  assign line = line_oe ? line_o : ~pull;

  sifc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .link_reset_n_i(link_n),
    .global_reset_n_i(glob_n), .cfg_rd_i(rd), .cfg_wr_i(wr),
    .cfg_addr_i(addr), .cfg_be_i(be), .cfg_wdata_i(wdata),
    .cfg_rdata_o(rdata), .cfg_ack_o(ack), .serial_interrupt_line_i(line),
    .serial_interrupt_line_o(line_o),
    .serial_interrupt_line_oe_o(line_oe), .irq_req_o(irq));
  sifc_periph u_periph (.clk_i(clk_i), .line_i(line),
    .slot_req_i(slot_req), .wake_i(wake), .pull_o(pull));

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // One access; strobe dropped a cycle before the next may start
  task automatic access(input logic w, input logic [7:0] a,
    input logic [3:0] b, input logic [31:0] d, output logic [31:0] q);
    rd = ~w;
    wr = w;
    addr = a;
    be = b;
    wdata = d;
    tick(1);
    rd = 1'b0;
    wr = 1'b0;
    check({31'h0, ack}, 32'h1);
    q = rdata;
    tick(1);
  endtask

  task automatic cwr(input logic [7:0] a, input logic [3:0] b,
    input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, b, d, q);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(1'b0, a, 4'hF, 32'h0, q);
    check(q, exp);
  endtask

  // Longest driven-low run over n runs; recovery checked after each
  task automatic runs(input int n, input logic drv, output int mx);
    int len;
    int guard;
    mx = 0;
    guard = 0;
    repeat (n)
    begin
      len = 0;
      while (!(line_oe === 1'b1 && line_o === 1'b0) && guard < 400)
      begin
        tick(1);
        guard++;
      end
      if (guard >= 400)
      begin
        n_errors++;
        report_and_stop();
      end
      while (line_oe === 1'b1 && line_o === 1'b0 && len < 20)
      begin
        len++;
        tick(1);
      end
      if (len > mx)
        mx = len;
      check({31'h0, line_oe}, {31'h0, ~drv});
      if (line_oe === 1'b1)
        check({31'h0, line_o}, 32'h1);
    end
  endtask

  task automatic t_regs();
    rchk(8'hE0, 32'h0);
    rchk(8'hE4, 32'h0);
    rchk(8'hE8, 32'h0);
    // Width code 11 is reserved, so it is never written
    cwr(8'hE0, 4'h1, 32'hF7);
    rchk(8'hE0, 32'h0000_0007);
    for (int k = 0; k < 2; k++)
    begin
      cwr(8'hE0, 4'hF, 32'hFFFF_FFF7);
      rchk(8'hE0, 32'hFFFF_0007);
      if (k == 0)
        link_n = 1'b0;
      else
        glob_n = 1'b0;
      tick(4);
      link_n = 1'b1;
      glob_n = 1'b1;
      tick(3);
      rchk(8'hE0, 32'h0);
    end
  endtask

  task automatic t_width();
    int mx;
    for (int c = 0; c < 3; c++)
    begin
      cwr(8'hE0, 4'h1, 32'((c << 2) | (c & 1)));
      runs(5, c[0], mx);
      check(32'(mx), 32'(4 + 2 * c));
    end
  endtask

  task automatic t_level();
    // Slots 0 and 5 level, slot 3 stays edge
    cwr(8'hE0, 4'hC, 32'h0021_0000);
    slot_req = 16'h0029;
    tick(130);
    check({16'h0, irq}, 32'h0029);
    slot_req = 16'h0000;
    tick(130);
    rchk(8'hE4, 32'h0021);
    check({16'h0, irq}, 32'h0021);
    cwr(8'hE4, 4'h1, 32'h0021);
    rchk(8'hE4, 32'h0);
    check({16'h0, irq}, 32'h0);
  endtask

  task automatic t_quiet();
    int cnt;
    cwr(8'hE0, 4'h1, 32'h2);
    tick(140);
    cnt = 0;
    repeat (30)
    begin
      tick(1);
      if (line_oe !== 1'b0)
        cnt++;
    end
    check(32'(cnt), 32'h0);
    wake = 1'b1;
    tick(1);
    wake = 1'b0;
    cnt = 0;
    while (!(line_oe === 1'b1 && line_o === 1'b0) && cnt < 10)
    begin
      tick(1);
      cnt++;
    end
    check({31'h0, cnt < 10}, 32'h1);
  endtask

  initial
  begin
    tick(8);
    rst_i = 1'b0;
    tick(2);
    t_regs();
    t_width();
    t_level();
    t_quiet();
    report_and_stop();
  end
endmodule
`default_nettype wire
